// File: tnc_pkg.sv
// constants shared by the trim, nonvolatile store and reset control
package tnc_pkg;
    // register offsets
    localparam logic [6:0] ADDR_STATUS = 7'h0f;
    localparam logic [6:0] ADDR_NVM_CONF = 7'h6a;
    localparam logic [6:0] ADDR_SELF_TEST = 7'h6d;
    localparam logic [6:0] ADDR_NV_SETTINGS = 7'h70;
    localparam logic [6:0] ADDR_TRIM0 = 7'h71;
    localparam logic [6:0] ADDR_TRIM1 = 7'h72;
    localparam logic [6:0] ADDR_TRIM2 = 7'h73;
    localparam logic [6:0] ADDR_PWR_CONF = 7'h7c;
    localparam logic [6:0] ADDR_PWR_CTRL = 7'h7d;
    localparam logic [6:0] ADDR_CMD = 7'h7e;
    // field positions
    localparam int ST_EN_BIT = 0;
    localparam int ST_SIGN_BIT = 2;
    localparam int ST_AMP_BIT = 3;
    localparam int NVM_PROG_EN_BIT = 1;
    localparam int NVS_OFF_EN_BIT = 3;
    localparam int PWR_ADV_PS_BIT = 0;
    localparam int PWR_AUX_EN_BIT = 0;
    localparam int PWR_ACC_EN_BIT = 2;
    localparam int STATUS_CMD_RDY_BIT = 4;
    // writable bit masks, reserved bits read as zero
    localparam logic [7:0] MASK_SELF_TEST = 8'h0d;
    localparam logic [7:0] MASK_NVM_CONF = 8'h02;
    localparam logic [7:0] MASK_NV_SETTINGS = 8'h0f;
    localparam logic [7:0] MASK_PWR_CONF = 8'h03;
    localparam logic [7:0] MASK_PWR_CTRL = 8'h05;
    // reset values
    localparam logic [7:0] RST_PWR_CONF = 8'h03;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // commands
    localparam logic [7:0] CMD_SOFT_RESET = 8'hb6;
    localparam logic [7:0] CMD_NVM_PROG = 8'ha0;
    // data path
    localparam int ACC_W = 16;
    localparam int AXES = 3;
    localparam int TRIM_SHIFT_2G = 6;
    localparam logic signed [ACC_W-1:0] SAMPLE_MAX = 16'sh7fff;
    localparam logic signed [ACC_W-1:0] SAMPLE_MIN = 16'sh8000;
    // nonvolatile store: settings byte plus three trims
    localparam int NVM_BYTES = 4;
    localparam int NVM_LOAD_CYC = 16;
    localparam int NVM_PROG_CYC = 4000;
    // soft reset execution delay
    localparam int CLK_MHZ = 40;
    localparam int SRST_MIN_NS = 500;
    localparam int SRST_MAX_NS = 1000;
    localparam int SRST_DLY_CYC = (SRST_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int SRST_MAX_CYC = SRST_MAX_NS * CLK_MHZ / 1000;
endpackage

// File: tnc_nvm_if.sv
// link between the register control and the nonvolatile store
`timescale 1ns/1ps
interface tnc_nvm_if;
    logic load_req;
    logic prog_req;
    logic busy;
    logic done;
    logic [31:0] image_to_nvm;
    logic [31:0] image_from_nvm;
    modport ctrl (output load_req, prog_req, image_to_nvm,
                  input busy, done, image_from_nvm);
    modport store (input load_req, prog_req, image_to_nvm,
                   output busy, done, image_from_nvm);
endinterface

// File: tnc_nvm_store.sv
// nonvolatile store model: image load and whole-array program cycle
`timescale 1ns/1ps
module tnc_nvm_store
    import tnc_pkg::*;
#(
    parameter int LOAD_CYC = NVM_LOAD_CYC,
    parameter int PROG_CYC = NVM_PROG_CYC,
    parameter logic [31:0] NVM_INIT = 32'h0000_0000
)
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // control side
    tnc_nvm_if.store nvm
);
    typedef enum logic [2:0]
    {
        S_IDLE = 3'b001,
        S_LOAD = 3'b010,
        S_PROG = 3'b100
    } tnc_nvm_state_e;

    tnc_nvm_state_e state, next_state;
    logic [15:0] cnt, next_cnt;
    logic [7:0] mem [NVM_BYTES];
    logic [7:0] next_mem [NVM_BYTES];
    logic done, next_done;

    // sequencing of load and program cycles
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_done = 1'b0;
        for (int i = 0; i < NVM_BYTES; i++)
        begin
            next_mem[i] = mem[i];
        end
        unique case (state)
            S_IDLE:
            begin
                if (nvm.load_req)
                begin
                    next_state = S_LOAD;
                    next_cnt = 16'(LOAD_CYC - 1);
                end
                else if (nvm.prog_req)
                begin
                    next_state = S_PROG;
                    next_cnt = 16'(PROG_CYC - 1);
                end
            end
            S_LOAD, S_PROG:
            begin
                if (cnt == 16'h0000)
                begin
                    next_state = S_IDLE;
                    next_done = 1'b1;
                    // whole array rewritten, never a partial update
                    if (state == S_PROG)
                    begin
                        for (int i = 0; i < NVM_BYTES; i++)
                        begin
                            next_mem[i] = nvm.image_to_nvm[8*i +: 8];
                        end
                    end
                end
                else
                begin
                    next_cnt = cnt - 16'h0001;
                end
            end
        endcase
    end

    // contents survive soft reset; only the async reset restores defaults
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state <= S_IDLE;
            cnt <= 16'h0000;
            done <= 1'b0;
            for (int i = 0; i < NVM_BYTES; i++)
            begin
                mem[i] <= NVM_INIT[8*i +: 8];
            end
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            done <= next_done;
            mem <= next_mem;
        end
    end

    assign nvm.busy = (state != S_IDLE);
    assign nvm.done = done;
    assign nvm.image_from_nvm = {mem[3], mem[2], mem[1], mem[0]};

    // program end commits the full image
    a_prog_commit: assert property (@(posedge i_sys_clk)
        disable iff (!i_reset_n)
        (state == S_PROG && cnt == 16'h0000)
        |=> (nvm.image_from_nvm == $past(nvm.image_to_nvm)) && done)
        else $error("program cycle did not store the image");

    c_prog_done: cover property (@(posedge i_sys_clk)
        disable iff (!i_reset_n)
        state == S_PROG ##1 state == S_IDLE);
endmodule

// File: tnc_trim_nvm_ctrl.sv
// register control for self-test, offset trim, nonvolatile image, reset
`timescale 1ns/1ps
// How it works
// - enable bit drives deflection, sign bit picks direction
// - self-test deflection arrives in the sensed data, no offset added here
// - trim added to both paths, saturating
// - 8-bit signed trim, 3.9 mg step
// - trim applied only while enable bit set
// - sample after a trim write flagged invalid
// - image registers writable, take effect immediately
// - reset loads image, ready low until done
// - program starts only outside deep power save
// - program rewrites whole store, ready low meanwhile
// - busy: writes dropped, reads return status
// - interface silent until boot load ends
// - command 0xb6 soft resets to stored defaults
// - soft reset executes after short delay, releases data
module tnc_trim_nvm_ctrl
    import tnc_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // register port from the serial interface
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [6:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_if_ready,
    // soft reset
    output logic o_soft_reset,
    output logic o_sda_release,
    // self-test and power
    output logic o_st_excite,
    output logic o_st_positive,
    output logic o_st_amp_high,
    output logic o_adv_power_save,
    output logic o_acc_en,
    output logic o_aux_en,
    output logic [7:0] o_nv_settings,
    // acceleration path
    input wire logic [1:0] i_acc_range,
    input wire logic i_pre_valid,
    input wire logic [AXES*ACC_W-1:0] i_pre_data,
    input wire logic i_flt_valid,
    input wire logic [AXES*ACC_W-1:0] i_flt_data,
    output logic o_pre_valid,
    output logic [AXES*ACC_W-1:0] o_pre_data,
    output logic o_flt_valid,
    output logic [AXES*ACC_W-1:0] o_flt_data,
    output logic o_sample_ok
);
    typedef enum logic [4:0]
    {
        C_BOOT_REQ = 5'b00001,
        C_BOOT_WAIT = 5'b00010,
        C_RUN = 5'b00100,
        C_PROG_WAIT = 5'b01000,
        C_SRST_DLY = 5'b10000
    } tnc_ctrl_state_e;

    localparam int SRST_LO = SRST_DLY_CYC;
    localparam int SRST_HI = SRST_MAX_CYC;

    tnc_nvm_if nvm ();

    tnc_ctrl_state_e state, next_state;
    logic [7:0] self_test, next_self_test;
    logic [7:0] nvm_conf, next_nvm_conf;
    logic [7:0] nv_set, next_nv_set;
    logic [7:0] trim [AXES];
    logic [7:0] next_trim [AXES];
    logic [7:0] pwr_conf, next_pwr_conf;
    logic [7:0] pwr_ctrl, next_pwr_ctrl;
    logic [5:0] srst_cnt, next_srst_cnt;
    logic load_req, next_load_req;
    logic prog_req, next_prog_req;
    logic soft_reset, next_soft_reset;
    logic [7:0] rdata, next_rdata;
    logic trim_dirty, next_trim_dirty;
    logic sample_ok, next_sample_ok;
    logic cmd_rdy;
    logic busy;
    logic wr_ok;
    logic [7:0] status_byte;

    assign cmd_rdy = (state == C_RUN) || (state == C_SRST_DLY);
    assign busy = !cmd_rdy;
    assign wr_ok = i_reg_wr && !busy;
    assign status_byte = 8'(cmd_rdy) << STATUS_CMD_RDY_BIT;

    // register writes, command decode, image load and soft reset
    always_comb
    begin
        next_state = state;
        next_self_test = self_test;
        next_nvm_conf = nvm_conf;
        next_nv_set = nv_set;
        next_trim = trim;
        next_pwr_conf = pwr_conf;
        next_pwr_ctrl = pwr_ctrl;
        next_srst_cnt = srst_cnt;
        next_load_req = 1'b0;
        next_prog_req = 1'b0;
        next_soft_reset = 1'b0;
        unique case (state)
            C_BOOT_REQ:
            begin
                next_load_req = 1'b1;
                next_state = C_BOOT_WAIT;
            end
            C_BOOT_WAIT:
            begin
                // images take the stored contents once the read finishes
                if (nvm.done && !load_req)
                begin
                    next_nv_set = nvm.image_from_nvm[7:0] & MASK_NV_SETTINGS;
                    for (int a = 0; a < AXES; a++)
                    begin
                        next_trim[a] = nvm.image_from_nvm[8*(a+1) +: 8];
                    end
                    next_state = C_RUN;
                end
            end
            C_RUN:
            begin
                if (wr_ok)
                begin
                    unique case (i_reg_addr)
                        ADDR_SELF_TEST: next_self_test = i_reg_wdata & MASK_SELF_TEST;
                        ADDR_NVM_CONF: next_nvm_conf = i_reg_wdata & MASK_NVM_CONF;
                        ADDR_NV_SETTINGS: next_nv_set = i_reg_wdata & MASK_NV_SETTINGS;
                        ADDR_TRIM0: next_trim[0] = i_reg_wdata;
                        ADDR_TRIM1: next_trim[1] = i_reg_wdata;
                        ADDR_TRIM2: next_trim[2] = i_reg_wdata;
                        ADDR_PWR_CONF: next_pwr_conf = i_reg_wdata & MASK_PWR_CONF;
                        ADDR_PWR_CTRL: next_pwr_ctrl = i_reg_wdata & MASK_PWR_CTRL;
                        ADDR_CMD:
                        begin
                            if (i_reg_wdata == CMD_SOFT_RESET)
                            begin
                                next_state = C_SRST_DLY;
                                next_srst_cnt = 6'(SRST_DLY_CYC - 1);
                            end
                            else if (i_reg_wdata == CMD_NVM_PROG
                                && nvm_conf[NVM_PROG_EN_BIT]
                                && !pwr_conf[PWR_ADV_PS_BIT])
                            begin
                                next_prog_req = 1'b1;
                                next_state = C_PROG_WAIT;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            C_PROG_WAIT:
            begin
                // request pulse is still in flight on the first cycle
                if (nvm.done && !prog_req)
                begin
                    next_state = C_RUN;
                end
            end
            C_SRST_DLY:
            begin
                if (srst_cnt == 6'h00)
                begin
                    // all user settings back to defaults, then reload
                    next_soft_reset = 1'b1;
                    next_self_test = RST_ZERO;
                    next_nvm_conf = RST_ZERO;
                    next_nv_set = RST_ZERO;
                    for (int a = 0; a < AXES; a++)
                    begin
                        next_trim[a] = RST_ZERO;
                    end
                    next_pwr_conf = RST_PWR_CONF;
                    next_pwr_ctrl = RST_ZERO;
                    next_state = C_BOOT_REQ;
                end
                else
                begin
                    next_srst_cnt = srst_cnt - 6'h01;
                end
            end
        endcase
    end

    // read data: status stands in for every address while busy
    always_comb
    begin
        next_rdata = o_reg_rdata;
        if (i_reg_rd && o_if_ready)
        begin
            if (busy)
            begin
                next_rdata = status_byte;
            end
            else
            begin
                unique case (i_reg_addr)
                    ADDR_STATUS: next_rdata = status_byte;
                    ADDR_SELF_TEST: next_rdata = self_test;
                    ADDR_NVM_CONF: next_rdata = nvm_conf;
                    ADDR_NV_SETTINGS: next_rdata = nv_set;
                    ADDR_TRIM0: next_rdata = trim[0];
                    ADDR_TRIM1: next_rdata = trim[1];
                    ADDR_TRIM2: next_rdata = trim[2];
                    ADDR_PWR_CONF: next_rdata = pwr_conf;
                    ADDR_PWR_CTRL: next_rdata = pwr_ctrl;
                    default: next_rdata = RST_ZERO;
                endcase
            end
        end
    end

    // a trim write spoils the next sample; a new write wins over clearing
    always_comb
    begin
        next_trim_dirty = trim_dirty;
        next_sample_ok = sample_ok;
        if (i_pre_valid)
        begin
            next_sample_ok = !trim_dirty;
            next_trim_dirty = 1'b0;
        end
        if (wr_ok && state == C_RUN && (i_reg_addr == ADDR_TRIM0
            || i_reg_addr == ADDR_TRIM1 || i_reg_addr == ADDR_TRIM2))
        begin
            next_trim_dirty = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state <= C_BOOT_REQ;
            self_test <= RST_ZERO;
            nvm_conf <= RST_ZERO;
            nv_set <= RST_ZERO;
            trim <= '{default: RST_ZERO};
            pwr_conf <= RST_PWR_CONF;
            pwr_ctrl <= RST_ZERO;
            srst_cnt <= 6'h00;
            load_req <= 1'b0;
            prog_req <= 1'b0;
            soft_reset <= 1'b0;
            o_reg_rdata <= 8'h00;
            trim_dirty <= 1'b0;
            sample_ok <= 1'b0;
        end
        else
        begin
            state <= next_state;
            self_test <= next_self_test;
            nvm_conf <= next_nvm_conf;
            nv_set <= next_nv_set;
            trim <= next_trim;
            pwr_conf <= next_pwr_conf;
            pwr_ctrl <= next_pwr_ctrl;
            srst_cnt <= next_srst_cnt;
            load_req <= next_load_req;
            prog_req <= next_prog_req;
            soft_reset <= next_soft_reset;
            o_reg_rdata <= next_rdata;
            trim_dirty <= next_trim_dirty;
            sample_ok <= next_sample_ok;
        end
    end

    assign nvm.load_req = load_req;
    assign nvm.prog_req = prog_req;
    assign nvm.image_to_nvm = {trim[2], trim[1], trim[0], nv_set};

    tnc_nvm_store u_store (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .nvm (nvm)
    );

    // silent during boot load; data line freed as the reset executes
    assign o_if_ready = (state != C_BOOT_REQ) && (state != C_BOOT_WAIT);
    assign o_soft_reset = soft_reset;
    assign o_sda_release = soft_reset;
    assign o_st_excite = self_test[ST_EN_BIT];
    assign o_st_positive = self_test[ST_SIGN_BIT];
    assign o_st_amp_high = self_test[ST_AMP_BIT];
    assign o_adv_power_save = pwr_conf[PWR_ADV_PS_BIT];
    assign o_acc_en = pwr_ctrl[PWR_ACC_EN_BIT];
    assign o_aux_en = pwr_ctrl[PWR_AUX_EN_BIT];
    assign o_nv_settings = nv_set;
    assign o_sample_ok = sample_ok;

    // trim step is range independent, so scale it to the data lsb
    function automatic logic signed [ACC_W-1:0] trim_sat(
        input logic signed [ACC_W-1:0] d,
        input logic signed [7:0] t,
        input logic [1:0] rng);
        logic signed [ACC_W+1:0] ext;
        logic signed [ACC_W+1:0] sum;
        ext = (ACC_W+2)'(t) <<< (3'(TRIM_SHIFT_2G) - {1'b0, rng});
        sum = (ACC_W+2)'(d) + ext;
        if (sum > (ACC_W+2)'(SAMPLE_MAX))
        begin
            return SAMPLE_MAX;
        end
        else if (sum < (ACC_W+2)'(SAMPLE_MIN))
        begin
            return SAMPLE_MIN;
        end
        return sum[ACC_W-1:0];
    endfunction

    // self-test deflection already sits in the sensed data, passed on
    logic [ACC_W-1:0] next_pre [AXES];
    logic [ACC_W-1:0] next_flt [AXES];
    genvar g;
    generate
        for (g = 0; g < AXES; g++)
        begin : g_axis
            assign next_pre[g] = !nv_set[NVS_OFF_EN_BIT] ?
                i_pre_data[g*ACC_W +: ACC_W] :
                trim_sat(i_pre_data[g*ACC_W +: ACC_W], trim[g], i_acc_range);
            assign next_flt[g] = !nv_set[NVS_OFF_EN_BIT] ?
                i_flt_data[g*ACC_W +: ACC_W] :
                trim_sat(i_flt_data[g*ACC_W +: ACC_W], trim[g], i_acc_range);
        end
    endgenerate

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_pre_valid <= 1'b0;
            o_flt_valid <= 1'b0;
            o_pre_data <= '0;
            o_flt_data <= '0;
        end
        else
        begin
            o_pre_valid <= i_pre_valid;
            o_flt_valid <= i_flt_valid;
            for (int a = 0; a < AXES; a++)
            begin
                if (i_pre_valid)
                begin
                    o_pre_data[a*ACC_W +: ACC_W] <= next_pre[a];
                end
                if (i_flt_valid)
                begin
                    o_flt_data[a*ACC_W +: ACC_W] <= next_flt[a];
                end
            end
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    a_st_enable: assert property (wr_ok && state == C_RUN
        && i_reg_addr == ADDR_SELF_TEST
        |=> o_st_excite == $past(i_reg_wdata[ST_EN_BIT])
            && o_st_positive == $past(i_reg_wdata[ST_SIGN_BIT]))
        else $error("self-test outputs do not follow the write");
    a_trim_bypass: assert property (i_pre_valid && !nv_set[NVS_OFF_EN_BIT]
        |=> o_pre_data == $past(i_pre_data))
        else $error("data altered while trim disabled");
    a_trim_clamp: assert property (i_pre_valid && nv_set[NVS_OFF_EN_BIT]
        && i_pre_data[ACC_W-1:0] == SAMPLE_MAX && !trim[0][7]
        |=> o_pre_data[ACC_W-1:0] == SAMPLE_MAX)
        else $error("positive overflow not saturated");
    a_trim_invalid: assert property (trim_dirty && i_pre_valid
        |=> !o_sample_ok)
        else $error("sample after trim write not flagged");
    a_boot_ready: assert property (state == C_BOOT_WAIT && nvm.done
        && !load_req |-> !o_if_ready ##1 o_if_ready && cmd_rdy)
        else $error("boot load did not end in ready");
    a_prog_gate: assert property (prog_req
        |-> !$past(pwr_conf[PWR_ADV_PS_BIT])
            && $past(nvm_conf[NVM_PROG_EN_BIT]))
        else $error("program started in deep power save");
    a_busy_discard: assert property (busy && i_reg_wr
        && state != C_BOOT_WAIT |=> $stable(trim[0]) && $stable(pwr_conf))
        else $error("write taken while busy");
    a_busy_status: assert property (busy && i_reg_rd && o_if_ready
        |=> o_reg_rdata == $past(status_byte))
        else $error("busy read did not return status");
    a_srst_delay: assert property (wr_ok && state == C_RUN
        && i_reg_addr == ADDR_CMD && i_reg_wdata == CMD_SOFT_RESET
        |-> !o_soft_reset [*2] ##[SRST_LO:SRST_HI] o_soft_reset)
        else $error("soft reset not executed in its window");

    c_soft_reset: cover property (o_soft_reset ##[1:40] o_if_ready);
    c_prog_cycle: cover property (state == C_PROG_WAIT ##1 state == C_RUN);
    c_self_test: cover property (o_st_excite && o_st_positive);
    c_saturate: cover property (o_pre_valid
        && o_pre_data[ACC_W-1:0] == SAMPLE_MAX && nv_set[NVS_OFF_EN_BIT]);
endmodule

// File: tnc_host_model.sv
// host model driving the register port of the control block
`timescale 1ns/1ps
module tnc_host_model
    import tnc_pkg::*;
(
    // clock and read data
    input wire logic i_sys_clk,
    input wire logic [7:0] i_rdata,
    // register strobes
    output logic o_wr,
    output logic o_rd,
    output logic [6:0] o_addr,
    output logic [7:0] o_wdata
);
    // idle bus until the first request
    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 7'h00;
        o_wdata = 8'h00;
    end
    // one-cycle write strobe, launched after an edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_sys_clk);
        o_wr <= 1'b0;
    endtask
    // read data is registered at the taking edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_sys_clk);
        o_rd <= 1'b0;
        #1 d = i_rdata;
    endtask
    // unlock needs power save off first, else the command is ignored
    task automatic prog();
        wr(ADDR_PWR_CONF, 8'h00);
        wr(ADDR_NVM_CONF, 8'h02);
        wr(ADDR_CMD, CMD_NVM_PROG);
    endtask
endmodule

// File: trim_nvm_selftest_reset_ctrl_tb.sv
// testbench: trim path, self-test, program cycle and soft reset
`timescale 1ns/1ps
module trim_nvm_selftest_reset_ctrl_tb
    import tnc_pkg::*;
;
    logic clk, rst_n, wr, rd, pv, rdy, srst, sda, ex, pos, psv, ok;
    logic amp, acc, aux, pvo, fvo;
    logic [1:0] rng;
    logic [6:0] adr;
    logic [7:0] wd, rdat, nvs;
    logic [47:0] pd, po, fo;
    int unsigned seed = 74;
    int num_errors = 0;
    int checked = 0;
    int tr[3];
    int en = 0;
    tnc_host_model host_u (.i_sys_clk(clk), .i_rdata(rdat), .o_wr(wr),
        .o_rd(rd), .o_addr(adr), .o_wdata(wd));
    tnc_trim_nvm_ctrl dut_u (.i_sys_clk(clk), .i_reset_n(rst_n),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(adr), .i_reg_wdata(wd),
        .o_reg_rdata(rdat), .o_if_ready(rdy), .o_soft_reset(srst),
        .o_sda_release(sda), .o_st_excite(ex), .o_st_positive(pos),
        .o_st_amp_high(amp), .o_adv_power_save(psv), .o_acc_en(acc),
        .o_aux_en(aux), .o_nv_settings(nvs), .i_acc_range(rng),
        .i_pre_valid(pv), .i_pre_data(pd), .i_flt_valid(pv),
        .i_flt_data(pd), .o_pre_valid(pvo), .o_pre_data(po),
        .o_flt_valid(fvo), .o_flt_data(fo), .o_sample_ok(ok));
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // saturating trim model, shift keeps the step range independent
    function automatic logic [47:0] model(logic [47:0] d);
        logic [47:0] r;
        int v;
        for (int i = 0; i < 3; i++)
        begin
            v = $signed(d[16*i +: 16]) + (tr[i] << (6 - rng)) * en;
            r[16*i +: 16] = v > 32767 ? 16'h7fff :
                v < -32768 ? 16'h8000 : v[15:0];
        end
        return r;
    endfunction
    task automatic chk(input logic [47:0] g, input logic [47:0] e);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_rdy();
        for (int n = 0; n < 300 && rdy !== 1'b1; n++)
            @(posedge clk);
        chk(rdy, 1'b1);
    endtask
    // one sample on both paths, checked after the registered answer
    task automatic smp(input logic [47:0] d, input logic k);
        @(posedge clk);
        pv <= 1'b1;
        pd <= d;
        @(posedge clk);
        pv <= 1'b0;
        #1;
        chk(po, model(d));
        chk(fo, model(d));
        chk({pvo, fvo}, 2'b11);
        chk(ok, k);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // watchdog sized well past the program cycle
    initial
    begin
        #(25 * 30000);
        num_errors++;
        finish_test();
    end
    initial
    begin
        logic [7:0] b, q;
        int n;
        {rst_n, pv, pd, rng} = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        host_u.wr(ADDR_TRIM1, 8'h55);
        wait_rdy();
        host_u.rd(ADDR_TRIM1, b);
        chk(b, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            b = k == 2 ? 8'h40 : 8'(rnd());
            tr[k] = $signed(b);
            host_u.wr(ADDR_TRIM0 + 7'(k), b);
            host_u.rd(ADDR_TRIM0 + 7'(k), q);
            chk(q, b);
        end
        smp({16'h7fff, 16'(rnd()), 16'h8000}, 1'b0);
        host_u.wr(ADDR_NV_SETTINGS, 8'h08);
        en = 1;
        // every range: the trim step must scale the same way
        for (int r = 0; r < 4; r++)
        begin
            rng <= 2'(r);
            smp({16'h7fff, 16'(rnd()), 16'h8000}, 1'b1);
        end
        // 8g before self-test; no sample judged while it settles
        rng <= 2'd2;
        for (int j = 0; j < 3; j++)
        begin
            b = j == 0 ? 8'h05 : j == 1 ? 8'h01 : 8'h00;
            host_u.wr(ADDR_SELF_TEST, b);
            #1 chk({ex, pos, amp}, {b[0], b[2], b[3]});
        end
        host_u.prog();
        // busy probes use non-image registers only
        host_u.wr(ADDR_PWR_CTRL, 8'h05);
        host_u.rd(ADDR_NVM_CONF, b);
        chk(b, 8'h00);
        for (n = 0; n < 3000 && b[STATUS_CMD_RDY_BIT] !== 1'b1; n++)
            host_u.rd(ADDR_STATUS, b);
        chk(b[STATUS_CMD_RDY_BIT], 1'b1);
        host_u.rd(ADDR_TRIM1, b);
        chk(b, 8'(tr[1]));
        chk({acc, aux}, 2'b00);
        host_u.wr(ADDR_TRIM0, 8'(tr[0] + 1));
        // reset after self-test; no clean ack wanted, power save back on after it
        host_u.wr(ADDR_CMD, CMD_SOFT_RESET);
        for (n = 0; n < 50 && srst !== 1'b1; n++)
            @(posedge clk) #1;
        chk(n >= SRST_DLY_CYC && n <= SRST_MAX_CYC
            && sda === 1'b1, 1'b1);
        repeat (3) @(posedge clk);
        #1 chk(rdy, 1'b0);
        wait_rdy();
        host_u.rd(ADDR_TRIM0, b);
        chk({b, psv, nvs}, {8'(tr[0]), 1'b1, 8'h08});
        finish_test();
    end
endmodule
